// ---- pkg/pes_params.svh ----
/*
 * Constants for the pin-event status capture block: register word indices,
 * field positions and reset values.
 * Assumes a 12-bit AXI4-Lite byte address; the byte address is four times the index.
 */
`ifndef PES_PARAMS_SVH
`define PES_PARAMS_SVH

// =====================================================================
// register word indices (byte address = index * 4)
`define PES_IDX_TOP 10'h000
`define PES_IDX_DIR 10'h090
`define PES_IDX_SMIEN 10'h092
`define PES_IDX_STAT4 10'h0f7
`define PES_IDX_PINEN 10'h100
`define PES_IDX_ISTAT 10'h101
`define PES_IDX_IMASK 10'h102

// =====================================================================
// field positions
`define PES_BIT_LINE2 7
`define PES_BIT_LINE1 6
`define PES_BIT_LINE0 5
`define PES_BIT_LIDPOS 4
`define PES_BIT_LIDEV 3
`define PES_BIT_LIDSEL 6
`define PES_BIT_TOPSUM 0

// =====================================================================
// reset values
`define PES_RST_DIR 8'h00
`define PES_RST_SMIEN 8'h00
`define PES_RST_PINEN 3'h0
`define PES_RST_IMASK 4'h0

// =====================================================================
// bus answers
`define PES_RESP_OKAY 2'h0
`define PES_RESP_DECERR 2'h3

`endif

// ---- pkg/pes_pkg.sv ----
/*
 * Types for the pin-event status capture block.
 * Assumes pes_params.svh is available on the include path.
 */
package pes_pkg;

   // =====================================================================
   // shared types
   typedef logic [3:0] pes_lines_t;   // [0..2] input lines, [3] lid line
   typedef logic [11:0] pes_addr_t;

   // synchroniser state
   typedef struct packed {
      pes_lines_t s1;
      pes_lines_t s2;
      pes_lines_t s3;
      pes_lines_t lvl;
      pes_lines_t chg;
      logic [1:0] fill;
   } pes_sync_s;

   // top-level state
   typedef struct packed {
      logic aw_rdy;
      logic w_rdy;
      logic aw_got;
      logic w_got;
      pes_addr_t awaddr;
      logic [7:0] wdata;
      logic wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] dir;
      logic [7:0] smien;
      logic [2:0] pinen;
      pes_lines_t flags;
      pes_lines_t istat;
      pes_lines_t imask;
      logic irq;
      logic mgmt;
   } pes_top_s;

endpackage : pes_pkg

// ---- pkg/pes_sync_if.sv ----
/*
 * Carrier between the top module and the pin synchroniser.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/10ps

interface pes_sync_if;
   import pes_pkg::*;
   pes_lines_t raw;      // asynchronous pin levels
   pes_lines_t level;    // filtered level
   pes_lines_t change;   // one-cycle pulse per accepted transition
   modport sync (input raw, output level, output change);
   modport user (output raw, input level, input change);
endinterface : pes_sync_if

// ---- verilog/pes_sync.sv ----
/*
 * Three-flop synchroniser and transition detector for the four event pins.
 * Assumes raw pins are asynchronous to CORE_CLK.
 */
`timescale 1ns/10ps

module pes_sync (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   pes_sync_if.sync intf
);
   import pes_pkg::*;

   pes_sync_s s_reg;
   pes_sync_s s_next;
   pes_lines_t agree;
   pes_lines_t new_lvl;

   // =====================================================================
   // filter: a change counts once the second and third flops agree
   assign agree = ~(s_reg.s2 ^ s_reg.s3);
   assign new_lvl = (agree & s_reg.s3) | (~agree & s_reg.lvl);

   // next state; first flop feeds only the second
   always_comb begin
      s_next = s_reg;
      s_next.s1 = intf.raw;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      s_next.lvl = new_lvl;
      // no pulse until the pipe holds real samples, avoids a false edge after reset
      s_next.chg = (s_reg.fill == 2'h3) ? (new_lvl ^ s_reg.lvl) : 4'h0;
      if (s_reg.fill != 2'h3) begin
         s_next.fill = s_reg.fill + 2'h1;
      end
   end

   // state register
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign intf.level = s_reg.lvl;
   assign intf.change = s_reg.chg;

   // =====================================================================
   // checks
   a_change_moves_level: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      s_reg.chg[0] |-> (s_reg.lvl[0] != $past(s_reg.lvl[0])))
      else $error("change pulse without level move");

endmodule : pes_sync

// ---- verilog/pes_top.sv ----
/*
 * Second-level management-interrupt status for three input lines and the lid line,
 * with direction, enable and pin-function registers behind an AXI4-Lite slave.
 * Assumes pins are asynchronous; one core clock; the bus master keeps AXI rules.
 */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "pes_params.svh"

module pes_top (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire pes_pkg::pes_addr_t AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire pes_pkg::pes_addr_t ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic INPUT_LINE_ZERO,
   input wire logic INPUT_LINE_ONE,
   input wire logic INPUT_LINE_TWO,
   input wire logic LID_INPUT_LINE_SIX,
   output logic MANAGEMENT_INTERRUPT,
   output logic IRQ
);
   import pes_pkg::*;

   pes_top_s s_reg;
   pes_top_s s_next;
   pes_lines_t qual;
   pes_lines_t ev;
   logic lid_pos;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic rd_clr;

   // =====================================================================
   // pin synchroniser
   pes_sync_if sync_bus ();

   assign sync_bus.raw = {LID_INPUT_LINE_SIX, INPUT_LINE_TWO, INPUT_LINE_ONE, INPUT_LINE_ZERO};

   pes_sync u_sync (
      .CORE_CLK(CORE_CLK),
      .RESETN(RESETN),
      .intf(sync_bus.sync)
   );

   // =====================================================================
   // event qualification
   // pin enable, input, interrupt enable
   assign qual[2:0] = s_reg.pinen & ~s_reg.dir[2:0] & s_reg.smien[2:0];
   // lid needs selection and input direction
   assign qual[3] = s_reg.smien[`PES_BIT_LIDSEL] & ~s_reg.dir[`PES_BIT_LIDSEL];
   assign ev = sync_bus.change & qual;
   // live lid level, zero when line six is not the lid switch
   assign lid_pos = s_reg.smien[`PES_BIT_LIDSEL] & sync_bus.level[3];

   // bus handshakes
   assign aw_hs = AWVALID & s_reg.aw_rdy;
   assign w_hs = WVALID & s_reg.w_rdy;
   assign ar_hs = ARVALID & s_reg.ar_rdy;
   assign rd_clr = ar_hs && (ARADDR[11:2] == `PES_IDX_STAT4);

   // =====================================================================
   // next state: bus slave, flags, interrupt
   always_comb begin
      logic [3:0] ist_clr;
      logic [31:0] rd;
      logic [1:0] rr;
      ist_clr = 4'h0;
      rd = 32'h0000_0000;
      rr = `PES_RESP_OKAY;
      s_next = s_reg;
      // write channels taken in either order
      if (aw_hs) begin
         s_next.aw_got = 1'b1;
         s_next.awaddr = AWADDR;
      end
      if (w_hs) begin
         s_next.w_got = 1'b1;
         s_next.wdata = WDATA[7:0];
         s_next.wstb = WSTRB[0];
      end
      if (s_reg.bvalid && BREADY) begin
         s_next.bvalid = 1'b0;
      end
      // commit once both halves are held; only byte lane 0 carries data
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = `PES_RESP_OKAY;
         unique case (s_reg.awaddr[11:2])
            `PES_IDX_DIR: begin
               if (s_reg.wstb) s_next.dir = s_reg.wdata;
            end
            `PES_IDX_SMIEN: begin
               if (s_reg.wstb) s_next.smien = s_reg.wdata;
            end
            `PES_IDX_PINEN: begin
               if (s_reg.wstb) s_next.pinen = s_reg.wdata[2:0];
            end
            `PES_IDX_ISTAT: begin
               if (s_reg.wstb) ist_clr = s_reg.wdata[3:0];
            end
            `PES_IDX_IMASK: begin
               if (s_reg.wstb) s_next.imask = s_reg.wdata[3:0];
            end
            `PES_IDX_TOP, `PES_IDX_STAT4: begin
               s_next.bresp = `PES_RESP_OKAY;   // read-only, write ignored
            end
            default: begin
               s_next.bresp = `PES_RESP_DECERR;
            end
         endcase
      end
      // read decode
      unique case (ARADDR[11:2])
         `PES_IDX_TOP: rd[`PES_BIT_TOPSUM] = |s_reg.flags;
         `PES_IDX_DIR: rd[7:0] = s_reg.dir;
         `PES_IDX_SMIEN: rd[7:0] = s_reg.smien;
         // lid level read without side effect
         `PES_IDX_STAT4: rd[7:0] = {s_reg.flags[2], s_reg.flags[1], s_reg.flags[0], lid_pos,
                                    s_reg.flags[3], 3'h0};
         `PES_IDX_PINEN: rd[2:0] = s_reg.pinen;
         `PES_IDX_ISTAT: rd[3:0] = s_reg.istat;
         `PES_IDX_IMASK: rd[3:0] = s_reg.imask;
         default: rr = `PES_RESP_DECERR;
      endcase
      if (s_reg.rvalid && RREADY) begin
         s_next.rvalid = 1'b0;
      end
      if (ar_hs) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd;
         s_next.rresp = rr;
      end
      // set wins over the read clear
      s_next.flags = (s_reg.flags & ~{4{rd_clr}}) | ev;
      // sticky interrupt status, write one to clear, event wins
      s_next.istat = (s_reg.istat & ~ist_clr) | ev;
      // readies drop while a transfer is held
      s_next.aw_rdy = !s_next.aw_got && !s_next.bvalid;
      s_next.w_rdy = !s_next.w_got && !s_next.bvalid;
      s_next.ar_rdy = !s_next.rvalid;
      s_next.irq = |(s_next.istat & s_next.imask);
      s_next.mgmt = |s_next.flags;
   end

   // state register; all reset values are zero
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // =====================================================================
   // outputs straight from flops
   assign AWREADY = s_reg.aw_rdy;
   assign WREADY = s_reg.w_rdy;
   assign BVALID = s_reg.bvalid;
   assign BRESP = s_reg.bresp;
   assign ARREADY = s_reg.ar_rdy;
   assign RVALID = s_reg.rvalid;
   assign RDATA = s_reg.rdata;
   assign RRESP = s_reg.rresp;
   assign MANAGEMENT_INTERRUPT = s_reg.mgmt;
   assign IRQ = s_reg.irq;

   // =====================================================================
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   a_line_two_sets: assert property (ev[2] |=> s_reg.flags[2])
      else $error("line two event lost");
   a_line_one_sets: assert property (ev[1] |=> s_reg.flags[1])
      else $error("line one event lost");
   a_line_zero_clear: assert property (rd_clr && !ev[0] |=> !s_reg.flags[0])
      else $error("line zero flag not cleared by read");
   a_lid_level_read: assert property ((rd_clr && lid_pos) |=> RDATA[`PES_BIT_LIDPOS])
      else $error("lid level not reported");
   a_lid_flag_gate: assert property ($rose(s_reg.flags[3]) |->
      $past(s_reg.smien[`PES_BIT_LIDSEL] && !s_reg.dir[`PES_BIT_LIDSEL]))
      else $error("lid flag set without selection and input");
   a_top_summary: assert property ($rose(|s_reg.flags) |-> MANAGEMENT_INTERRUPT)
      else $error("top summary missing");
   a_lid_unselected: assert property (!s_reg.smien[`PES_BIT_LIDSEL] |-> ##1 !$rose(s_reg.flags[3]))
      else $error("lid flag set while not selected");
   a_line_unconfig: assert property ($rose(s_reg.flags[0]) |->
      $past(s_reg.pinen[0] && !s_reg.dir[0] && s_reg.smien[0]))
      else $error("line zero flag set while unconfigured");
   a_set_beats_clear: assert property ((rd_clr && ev[1]) |=> s_reg.flags[1])
      else $error("event lost under read clear");
   a_write_answer: assert property ((s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) |=> BVALID)
      else $error("write response late");
   a_irq_follows: assert property ((ev[0] && s_reg.imask[0]) |=> IRQ)
      else $error("unmasked event gave no interrupt");

endmodule : pes_top

// ---- dv/pes_pin_model.sv ----
/*
 * Model of the outside world at the four event pins: three input lines and the lid switch.
 * Assumes it is clocked by the core clock and drives every pin at all times, so no pin floats.
 */
`timescale 1ns/10ps

module pes_pin_model (
   input wire logic clk,
   output logic [3:0] pins
);
   // =====================================================================
   // pin levels
   initial begin
      pins = 4'h0;
   end

   // one edge on a pin, held 3 cycles because narrower pulses may be lost
   task automatic flip(input int i);
      pins[i] <= ~pins[i];
      repeat (3) @(posedge clk);
   endtask : flip
endmodule : pes_pin_model

// ---- dv/pin_event_smi_status_capture_bench.sv ----
/*
 * Register-level bench for the pin-event status capture block over AXI4-Lite.
 * Assumes pes_pkg, pes_params.svh, pes_sync_if and the pin model are compiled first.
 */
`timescale 1ns/10ps
`include "pes_params.svh"

module pin_event_smi_status_capture_bench;
   import pes_pkg::*;
   logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, mgmt, irq;
   pes_addr_t awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb, pins;
   logic [1:0] bresp, rresp, r;
   int bad_count = 0;
   int n_tests = 0;

   // =====================================================================
   // clock, design and pins
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   pes_pin_model u_pes_pin_model (.clk(clk), .pins(pins));
   pes_top u_pes_top (.CORE_CLK(clk), .RESETN(rstn), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .INPUT_LINE_ZERO(pins[0]), .INPUT_LINE_ONE(pins[1]),
      .INPUT_LINE_TWO(pins[2]), .LID_INPUT_LINE_SIX(pins[3]), .MANAGEMENT_INTERRUPT(mgmt), .IRQ(irq));

   // =====================================================================
   // bus tasks, each entered just after a rising edge
   function automatic pes_addr_t ba(input logic [9:0] idx);
      return {idx, 2'b00};
   endfunction : ba

   // address and data offered together, each dropped when its own ready is seen
   task automatic wr(input pes_addr_t a, input logic [7:0] v);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // valid still reads its pre-edge value here, so a channel is pending until its ready is seen
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input pes_addr_t a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // live lid level as it should read in bit 4 while the lid is selected
   function automatic logic [31:0] lvl;
      return {27'h0, pins[3], 4'h0};
   endfunction : lvl

   // a misconfigured line must not raise its flag
   task automatic unqual(input logic [7:0] dir, input logic [7:0] pen, input logic [7:0] en, input int i);
      wr(ba(`PES_IDX_DIR), dir);
      wr(ba(`PES_IDX_PINEN), pen);
      wr(ba(`PES_IDX_SMIEN), en);
      u_pes_pin_model.flip(i);
      repeat (8) @(posedge clk);
      chk("mgmt_unqual", {31'h0, mgmt}, 32'h0);
      rd(ba(`PES_IDX_STAT4));
      chk("stat4_unqual", d, lvl());
   endtask : unqual

   // =====================================================================
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      stop_test();
   end

   // =====================================================================
   // main sequence
   initial begin
      rstn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'h1;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      // dir, imask, stat4, smien and top registers start at zero
      rd(ba(`PES_IDX_DIR));
      chk("dir_rst", d, 32'h0);
      rd(ba(`PES_IDX_IMASK));
      chk("imask_rst", d, 32'h0);
      rd(ba(`PES_IDX_STAT4));
      chk("stat4_rst", d, 32'h0);
      rd(ba(`PES_IDX_SMIEN));
      chk("smien_rst", d, 32'h0);
      rd(ba(`PES_IDX_TOP));
      chk("top_rst", d, 32'h0);
      // unmapped place answers with a decode error and zero data
      rd(12'h500);
      chk("unmapped_resp", {30'h0, r}, {30'h0, `PES_RESP_DECERR});
      chk("unmapped_data", d, 32'h0);
      wr(12'h500, 8'h00);
      chk("unmapped_wresp", {30'h0, r}, {30'h0, `PES_RESP_DECERR});
      wr(ba(`PES_IDX_PINEN), 8'h07);
      wr(ba(`PES_IDX_SMIEN), 8'h47);
      wr(ba(`PES_IDX_IMASK), 8'h0f);
      // each line in turn: flag, summary, clear on read, interrupt status
      for (int i = 0; i < 4; i++) begin
         u_pes_pin_model.flip(i);
         repeat (8) @(posedge clk);
         chk("mgmt_set", {31'h0, mgmt}, 32'h1);
         chk("irq_set", {31'h0, irq}, 32'h1);
         rd(ba(`PES_IDX_TOP));
         chk("top_set", d, 32'h1);
         wr(ba(`PES_IDX_STAT4), 8'hff);
         rd(ba(`PES_IDX_STAT4));
         chk("stat4_set", d, lvl() | (i == 3 ? 32'h08 : 32'h20 << i));
         rd(ba(`PES_IDX_STAT4));
         chk("stat4_clr", d, lvl());
         chk("mgmt_clr", {31'h0, mgmt}, 32'h0);
         rd(ba(`PES_IDX_ISTAT));
         chk("istat_set", d, 32'h1 << i);
         wr(ba(`PES_IDX_ISTAT), 8'h1 << i);
         repeat (2) @(posedge clk);
         chk("irq_clr", {31'h0, irq}, 32'h0);
      end
      // lid as output, line not pin-enabled, line not interrupt-enabled
      unqual(8'h40, 8'h07, 8'h47, 3);
      unqual(8'h00, 8'h06, 8'h47, 0);
      unqual(8'h00, 8'h07, 8'h43, 2);
      // masked event holds the interrupt low until unmasked
      wr(ba(`PES_IDX_SMIEN), 8'h47);
      wr(ba(`PES_IDX_IMASK), 8'h00);
      u_pes_pin_model.flip(1);
      repeat (8) @(posedge clk);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(ba(`PES_IDX_IMASK), 8'h0f);
      repeat (2) @(posedge clk);
      chk("irq_unmasked", {31'h0, irq}, 32'h1);
      wr(ba(`PES_IDX_ISTAT), 8'h02);
      rd(ba(`PES_IDX_STAT4));
      chk("stat4_line1", d, lvl() | 32'h40);
      repeat (2) @(posedge clk);
      chk("irq_w1c", {31'h0, irq}, 32'h0);
      // event pulse lands on the edge that takes the clearing read: flag must survive
      u_pes_pin_model.flip(1);
      @(posedge clk);
      rd(ba(`PES_IDX_STAT4));
      chk("stat4_race_rd", d, lvl());
      rd(ba(`PES_IDX_STAT4));
      chk("stat4_race_kept", d, lvl() | 32'h40);
      // lid deselected: level bit reads zero even with the pin high, and no lid event
      wr(ba(`PES_IDX_SMIEN), 8'h07);
      u_pes_pin_model.flip(3);
      repeat (8) @(posedge clk);
      rd(ba(`PES_IDX_STAT4));
      chk("lid_desel", d, 32'h0);
      // mid-run reset returns status and registers to zero
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      chk("irq_rst", {31'h0, irq}, 32'h0);
      rd(ba(`PES_IDX_SMIEN));
      chk("smien_rst2", d, 32'h0);
      stop_test();
   end
endmodule : pin_event_smi_status_capture_bench
